/* File: logic/sppsix_buf.sv */
`timescale 1ns/10ps
module sppsix_buf #(
    parameter int WIDTH = sppsix_pkg::PORT_W,
    parameter int DEPTH = sppsix_pkg::BUF_DEPTH
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstnSync,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    import sppsix_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] rdPtr;
        logic [CW-1:0] count;
    } sppsix_buf_state_t;

    sppsix_buf_state_t st_r;
    sppsix_buf_state_t st_nxt;
    logic push;
    logic pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign inReady = (st_r.count != CW'(DEPTH));
    assign outValid = (st_r.count != '0);
    assign outData = st_r.mem[st_r.rdPtr];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wrPtr] = inData;
            st_nxt.wrPtr = bump(st_r.wrPtr);
        end
        if (pop) begin
            st_nxt.rdPtr = bump(st_r.rdPtr);
        end
        if (push && !pop) begin
            st_nxt.count = st_r.count + 1'b1;
        end else if (pop && !push) begin
            st_nxt.count = st_r.count - 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rstnSync) begin
        if (!rstnSync) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule // sppsix_buf

/* File: logic/sppsix_pkg.sv */
package sppsix_pkg;

    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [7:0] ADDR_PORTA = 8'hc0;
    localparam logic [7:0] ADDR_PORTB = 8'hc8;
    localparam logic [7:0] ADDR_STROBED = 8'hd8;
    localparam logic [7:0] ADDR_CTRL = 8'he8;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] CTRL_RESET = 8'hfc;
    localparam logic [7:0] LATCH_RESET = 8'hff;

    // ****************************************
    // Control/status field positions
    // ****************************************
    localparam int CTRL_IBF = 0;
    localparam int CTRL_OBF = 1;
    localparam int CTRL_IN_STROBE_STYLE = 2;
    localparam int CTRL_OUT_FLAG_CLEAR_EDGE = 3;
    localparam int CTRL_AMODE = 4;
    localparam int CTRL_BMODE = 6;
    localparam logic [7:0] CTRL_WMASK = 8'hfc;

    // ****************************************
    // Widths
    // ****************************************
    localparam int PORT_W = 8;
    localparam int PORTA_W = 8;
    localparam int BUF_DEPTH = 2;

    // ****************************************
    // Flag pin modes
    // ****************************************
    typedef enum logic [1:0] {
        FLAG_LO = 2'b00,
        FLAG_HI = 2'b01,
        FLAG_BUF = 2'b10,
        FLAG_IN = 2'b11
    } sppsix_flag_t;

endpackage

/* File: logic/sppsix_top.sv */
// Notes on behaviour
// RULE1 - Control register sets modes, shows flags
// RULE2 - All control bits writable except two lowest
// RULE3 - Reset loads ones into 7:2, zeros 1:0
// RULE4 - Three port latches behave like standard ports
// RULE5 - Two added ports are plain quasi-bidirectional
// RULE6 - First added port may be four bits
// RULE7 - Strobed port eight bits, pulled up
// RULE8 - Strobed port plain or four-line handshake
// RULE9 - Host pulls output strobe low to read
// RULE10 - Host pulls input strobe low to write
// RULE11 - B pin: input-full, enable input, fixed level
// RULE12 - A pin: output-full, select input, fixed level
// RULE13 - Bus interface, plain port, or printer port
// RULE14 - B codes: low, high, input-full, enable
// RULE15 - A codes: low, high, output-full, select
// RULE16 - Clear edge and input latch style bits
// RULE17 - Output-always mode drives port continuously
// RULE18 - Flags set by data, cleared by consumer
`timescale 1ns/10ps
module sppsix_top #(
    parameter int PORTA_W = sppsix_pkg::PORTA_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register access
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire logic sfrRmw,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    // Added port A
    input wire logic [PORTA_W-1:0] portAIn,
    output logic [PORTA_W-1:0] portAOut,
    output logic [PORTA_W-1:0] portAOe,
    // Added port B
    input wire logic [sppsix_pkg::PORT_W-1:0] portBIn,
    output logic [sppsix_pkg::PORT_W-1:0] portBOut,
    output logic [sppsix_pkg::PORT_W-1:0] portBOe,
    // Strobed port
    input wire logic [sppsix_pkg::PORT_W-1:0] strobedIn,
    output logic [sppsix_pkg::PORT_W-1:0] strobedOut,
    output logic [sppsix_pkg::PORT_W-1:0] strobedOe,
    // Handshake lines
    input wire logic inStrobeN,
    input wire logic outStrobeN,
    input wire logic pinACtlIn,
    output logic pinACtlOut,
    output logic pinACtlOe,
    input wire logic pinBCtlIn,
    output logic pinBCtlOut,
    output logic pinBCtlOe,
    output logic inRoom
);
    import sppsix_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0] ctrl;
        logic out_buffer_full;
        logic lvlIbf;
        logic [PORT_W-1:0] lvlData;
        logic [PORTA_W-1:0] latchA;
        logic [PORT_W-1:0] latchB;
        logic [PORT_W-1:0] latchS;
        logic [7:0] rdata;
        logic inPrev;
        logic outPrev;
        logic [PORTA_W-1:0] aOut;
        logic [PORTA_W-1:0] aOe;
        logic [PORT_W-1:0] bOut;
        logic [PORT_W-1:0] bOe;
        logic [PORT_W-1:0] sOut;
        logic [PORT_W-1:0] sOe;
        logic pinAOut;
        logic pinAOe;
        logic pinBOut;
        logic pinBOe;
        logic inRoom;
    } sppsix_state_t;

    sppsix_state_t st_r;
    sppsix_state_t st_nxt;
    logic [1:0] rstSync_r;
    logic rstnSync;
    sppsix_flag_t bMode;
    sppsix_flag_t aMode;
    logic levelMode;
    logic portOk;
    logic selCtl;
    logic outAlways;
    logic inRise;
    logic outFall;
    logic outRise;
    logic cpuRdS;
    logic cpuWrS;
    logic pushValid;
    logic popReq;
    logic bufReady;
    logic bufValid;
    logic [PORT_W-1:0] bufData;
    logic in_buffer_full;
    logic obfClr;
    logic drive;

    function automatic sppsix_flag_t flagMode(input logic [7:0] c,
                                              input int pos);
        flagMode = sppsix_flag_t'(c[pos+:2]);
    endfunction

    function automatic logic [7:0] csrValue(input logic [7:0] c,
                                            input logic o,
                                            input logic i);
        csrValue = {c[7:2], o, i};
    endfunction

    function automatic logic [7:0] portRead(input logic rmw,
                                            input logic [7:0] latch,
                                            input logic [7:0] pin);
        portRead = rmw ? latch : pin;
    endfunction

    // ****************************************
    // Reset release
    // ****************************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rstSync_r <= 2'h0;
        end else begin
            rstSync_r <= {rstSync_r[0], 1'b1};
        end
    end
    assign rstnSync = rstSync_r[1];

    // ****************************************
    // Mode decode
    // ****************************************
    // RULE1 mode field decode
    assign bMode = flagMode(st_r.ctrl, CTRL_BMODE);
    assign aMode = flagMode(st_r.ctrl, CTRL_AMODE);
    assign levelMode = st_r.ctrl[CTRL_IN_STROBE_STYLE];
    // RULE11 enable input low
    assign portOk = (bMode != FLAG_IN) || !pinBCtlIn;
    // RULE12 select input high
    assign selCtl = (aMode == FLAG_IN) && pinACtlIn;
    // RULE17 output-always decode
    assign outAlways = !bMode[1] && (aMode == FLAG_BUF);
    // RULE9 RULE10 strobe edges
    assign inRise = !st_r.inPrev && inStrobeN;
    assign outFall = st_r.outPrev && !outStrobeN;
    assign outRise = !st_r.outPrev && outStrobeN;
    assign cpuRdS = sfrRead && (sfrAddr == ADDR_STROBED);
    assign cpuWrS = sfrWrite && (sfrAddr == ADDR_STROBED);
    // RULE16 rising-edge latch into buffer
    assign pushValid = inRise && portOk && !levelMode;
    assign popReq = cpuRdS && !levelMode;
    assign in_buffer_full = levelMode ? st_r.lvlIbf : bufValid;
    // RULE16 clear edge select
    assign obfClr = (st_r.ctrl[CTRL_OUT_FLAG_CLEAR_EDGE] ? outRise : outFall) &&
                    portOk && !selCtl;
    // RULE8 RULE13 drive while strobed or always
    assign drive = portOk && (outAlways || !outStrobeN);

    sppsix_buf #(
        .WIDTH(PORT_W),
        .DEPTH(BUF_DEPTH)
    ) inBuf (
        .clock(clock),
        .rstnSync(rstnSync),
        .inValid(pushValid),
        .inReady(bufReady),
        .inData(strobedIn),
        .outValid(bufValid),
        .outReady(popReq),
        .outData(bufData)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.inPrev = inStrobeN;
        st_nxt.outPrev = outStrobeN;
        // RULE4 latch writes
        if (sfrWrite) begin
            case (sfrAddr)
                ADDR_PORTA: st_nxt.latchA = sfrWdata[PORTA_W-1:0];
                ADDR_PORTB: st_nxt.latchB = sfrWdata;
                ADDR_STROBED: st_nxt.latchS = sfrWdata;
                // RULE2 low bits ignore writes
                ADDR_CTRL: st_nxt.ctrl = sfrWdata & CTRL_WMASK;
                default: ;
            endcase
        end
        // RULE18 write sets, strobe clears
        if (cpuWrS) begin
            st_nxt.out_buffer_full = 1'b1;
        end else if (obfClr) begin
            st_nxt.out_buffer_full = 1'b0;
        end
        // RULE16 low-level transparent latch
        if (levelMode && !inStrobeN && portOk) begin
            st_nxt.lvlIbf = 1'b1;
            st_nxt.lvlData = strobedIn;
        end else if (cpuRdS && levelMode) begin
            st_nxt.lvlIbf = 1'b0;
        end
        if (sfrRead) begin
            case (sfrAddr)
                ADDR_PORTA: st_nxt.rdata = portRead(sfrRmw,
                    8'(st_r.latchA), 8'(portAIn));
                ADDR_PORTB: st_nxt.rdata = portRead(sfrRmw,
                    st_r.latchB, portBIn);
                ADDR_STROBED: st_nxt.rdata = levelMode ?
                    st_r.lvlData : bufData;
                ADDR_CTRL: st_nxt.rdata = csrValue(st_r.ctrl,
                    st_r.out_buffer_full, in_buffer_full);
                default: st_nxt.rdata = 8'h00;
            endcase
        end
        // RULE5 RULE6 quasi drive low only
        st_nxt.aOut = st_nxt.latchA;
        st_nxt.aOe = ~st_nxt.latchA;
        st_nxt.bOut = st_nxt.latchB;
        st_nxt.bOe = ~st_nxt.latchB;
        // RULE7 RULE15 data or status onto port
        st_nxt.sOut = selCtl ? csrValue(st_r.ctrl, st_r.out_buffer_full, in_buffer_full) :
                      st_r.latchS;
        st_nxt.sOe = drive ? 8'hff : 8'h00;
        // RULE14 B pin modes
        case (bMode)
            FLAG_LO: {st_nxt.pinBOut, st_nxt.pinBOe} = 2'h1;
            FLAG_HI: {st_nxt.pinBOut, st_nxt.pinBOe} = 2'h3;
            FLAG_BUF: {st_nxt.pinBOut, st_nxt.pinBOe} = {in_buffer_full, 1'b1};
            default: {st_nxt.pinBOut, st_nxt.pinBOe} = 2'h0;
        endcase
        // RULE15 A pin modes
        case (aMode)
            FLAG_LO: {st_nxt.pinAOut, st_nxt.pinAOe} = 2'h1;
            FLAG_HI: {st_nxt.pinAOut, st_nxt.pinAOe} = 2'h3;
            FLAG_BUF: {st_nxt.pinAOut, st_nxt.pinAOe} = {st_r.out_buffer_full, 1'b1};
            default: {st_nxt.pinAOut, st_nxt.pinAOe} = 2'h0;
        endcase
        st_nxt.inRoom = bufReady;
    end

    always_ff @(posedge clock or negedge rstnSync) begin
        if (!rstnSync) begin
            st_r <= '0;
            // RULE3 reset pattern
            st_r.ctrl <= CTRL_RESET;
            st_r.latchA <= PORTA_W'(LATCH_RESET);
            st_r.latchB <= LATCH_RESET;
            st_r.latchS <= LATCH_RESET;
            st_r.aOut <= PORTA_W'(LATCH_RESET);
            st_r.bOut <= LATCH_RESET;
            st_r.sOut <= LATCH_RESET;
            st_r.inPrev <= 1'b1;
            st_r.outPrev <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sfrRdata = st_r.rdata;
    assign portAOut = st_r.aOut;
    assign portAOe = st_r.aOe;
    assign portBOut = st_r.bOut;
    assign portBOe = st_r.bOe;
    assign strobedOut = st_r.sOut;
    assign strobedOe = st_r.sOe;
    assign pinACtlOut = st_r.pinAOut;
    assign pinACtlOe = st_r.pinAOe;
    assign pinBCtlOut = st_r.pinBOut;
    assign pinBCtlOe = st_r.pinBOe;
    assign inRoom = st_r.inRoom;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking dcb @(posedge clock); endclocking
    default disable iff (!rstnSync);

    property p_ctrlWrite;
        sfrWrite && sfrAddr == ADDR_CTRL |=>
            st_r.ctrl == ($past(sfrWdata) & CTRL_WMASK);
    endproperty
    a_ctrlWrite: assert property (p_ctrlWrite) // RULE2
        else $error("control write not stored as masked");

    property p_ctrlRead;
        sfrRead && sfrAddr == ADDR_CTRL |=>
            sfrRdata[CTRL_OBF] == $past(st_r.out_buffer_full) &&
            sfrRdata[CTRL_IBF] == $past(in_buffer_full);
    endproperty
    a_ctrlRead: assert property (p_ctrlRead) // RULE1
        else $error("status read does not show flags");

    property p_resetCtrl;
        $rose(rstnSync) |-> st_r.ctrl == CTRL_RESET && !st_r.out_buffer_full;
    endproperty
    a_resetCtrl: assert property (p_resetCtrl) // RULE3
        else $error("control value wrong after reset");

    property p_obfSet;
        cpuWrS |=> st_r.out_buffer_full ##1 (st_r.out_buffer_full || $past(obfClr));
    endproperty
    a_obfSet: assert property (p_obfSet) // RULE18
        else $error("output full flag not set by write");

    property p_obfFall;
        !st_r.ctrl[CTRL_OUT_FLAG_CLEAR_EDGE] && outFall && portOk && !selCtl &&
            !cpuWrS |=> !st_r.out_buffer_full;
    endproperty
    a_obfFall: assert property (p_obfFall) // RULE16
        else $error("falling strobe did not clear output flag");

    property p_ibfSet;
        pushValid && bufReady && !sfrWrite |=> in_buffer_full;
    endproperty
    a_ibfSet: assert property (p_ibfSet) // RULE18
        else $error("input strobe did not set input flag");

    property p_bflagLo;
        (bMode == FLAG_LO) [*2] |-> !pinBCtlOut && pinBCtlOe;
    endproperty
    a_bflagLo: assert property (p_bflagLo) // RULE14
        else $error("B pin not driving low");

    property p_aflagObf;
        (aMode == FLAG_BUF) [*2] |->
            pinACtlOe && pinACtlOut == $past(st_r.out_buffer_full);
    endproperty
    a_aflagObf: assert property (p_aflagObf) // RULE15
        else $error("A pin not showing output flag");

    property p_outAlways;
        outAlways && portOk |=> strobedOe == 8'hff;
    endproperty
    a_outAlways: assert property (p_outAlways) // RULE17
        else $error("output-always mode not driving");

    property p_peOff;
        bMode == FLAG_IN && pinBCtlIn |=> strobedOe == 8'h00;
    endproperty
    a_peOff: assert property (p_peOff) // RULE11
        else $error("port drives while disabled");

    property p_quasiA;
        sfrWrite && sfrAddr == ADDR_PORTA |=>
            portAOe == ~PORTA_W'($past(sfrWdata));
    endproperty
    a_quasiA: assert property (p_quasiA) // RULE5
        else $error("quasi port drive does not follow latch");

    property p_latchRead;
        sfrRead && sfrRmw && sfrAddr == ADDR_PORTB |=>
            sfrRdata == $past(st_r.latchB);
    endproperty
    a_latchRead: assert property (p_latchRead) // RULE4
        else $error("latch read returns wrong value");

    c_bufFull: cover property (pushValid ##[1:40] !bufReady);
    c_obfCycle: cover property (cpuWrS ##[1:40] obfClr);
    c_statusOut: cover property (selCtl && drive);
    c_level: cover property (levelMode && !inStrobeN && portOk);

endmodule // sppsix_top

/* File: sim/sppsix_host.sv */
`timescale 1ns/10ps
module sppsix_host (
    // Clock
    input wire logic clock,
    // Strobed port lines
    input wire logic [sppsix_pkg::PORT_W-1:0] strobedOut,
    input wire logic [sppsix_pkg::PORT_W-1:0] strobedOe,
    output logic [sppsix_pkg::PORT_W-1:0] strobedIn,
    output logic inStrobeN,
    output logic outStrobeN,
    // Flag pins
    input wire logic pinACtlOut,
    input wire logic pinACtlOe,
    input wire logic pinBCtlOut,
    input wire logic pinBCtlOe,
    output logic pinACtlIn,
    output logic pinBCtlIn
);
    import sppsix_pkg::*;
    logic drive = 1'b0;
    logic selLvl = 1'b0;
    logic peLvl = 1'b0;
    logic [7:0] hostData = 8'h00;

    initial begin
        inStrobeN = 1'b1;
        outStrobeN = 1'b1;
    end

    // Undriven data lines float high on pullups; undriven flag pins take the host levels selLvl and peLvl
    assign strobedIn = drive ? hostData : (strobedOut | ~strobedOe);
    assign pinACtlIn = pinACtlOe ? pinACtlOut : selLvl;
    assign pinBCtlIn = pinBCtlOe ? pinBCtlOut : peLvl;

    task automatic put(input logic [7:0] v);
        @(posedge clock);
        drive <= 1'b1;
        hostData <= v;
        inStrobeN <= 1'b0;
        @(posedge clock);
        inStrobeN <= 1'b1;
        @(posedge clock);
        @(posedge clock);
        drive <= 1'b0;
    endtask

    task automatic get(output logic [7:0] v);
        int n;
        @(posedge clock);
        outStrobeN <= 1'b0;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (strobedOe !== 8'hff && n < 6);
        v = strobedIn;
    endtask

    task automatic lift();
        @(posedge clock);
        outStrobeN <= 1'b1;
        repeat (3) @(posedge clock);
    endtask
endmodule // sppsix_host

/* File: sim/tb.sv */
`timescale 1ns/10ps
module tb;
    import sppsix_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic sfrWrite = 1'b0;
    logic sfrRead = 1'b0;
    logic sfrRmw = 1'b0;
    logic rdSeen = 1'b0;
    logic [7:0] sfrAddr = 8'h00;
    logic [7:0] sfrWdata = 8'h00;
    logic [7:0] extA = 8'hff;
    logic [7:0] extB = 8'hff;
    logic [7:0] sfrRdata, portAOut, portAOe, portBOut, portBOe, portAIn;
    logic [7:0] portBIn, strobedIn, strobedOut, strobedOe, x, d, ct;
    logic inStrobeN, outStrobeN, pinACtlIn, pinACtlOut, pinACtlOe;
    logic pinBCtlIn, pinBCtlOut, pinBCtlOe, inRoom;
    logic [7:0] narrowRdata;
    logic [3:0] narrowAOut;
    logic [7:0] expQ[$];
    int miscompares = 0;
    int nChecks = 0;
    int seed = 32'hdb4d;

    // Quasi pins: latch pulls low, outside world may too
    assign portAIn = portAOut & extA;
    assign portBIn = portBOut & extB;

    sppsix_top dut_u (.clock, .rstn, .sfrAddr, .sfrWrite, .sfrRead,
        .sfrRmw, .sfrWdata, .sfrRdata, .portAIn, .portAOut, .portAOe,
        .portBIn, .portBOut, .portBOe, .strobedIn, .strobedOut,
        .strobedOe, .inStrobeN, .outStrobeN, .pinACtlIn, .pinACtlOut,
        .pinACtlOe, .pinBCtlIn, .pinBCtlOut, .pinBCtlOe, .inRoom);

    // Reduced first added port, sharing the register bus
    sppsix_top #(.PORTA_W(4)) narrow_u (.clock, .rstn, .sfrAddr,
        .sfrWrite, .sfrRead, .sfrRmw, .sfrWdata, .sfrRdata(narrowRdata),
        .portAIn(portAIn[3:0]), .portAOut(narrowAOut), .portAOe(),
        .portBIn, .portBOut(), .portBOe(), .strobedIn, .strobedOut(),
        .strobedOe(), .inStrobeN, .outStrobeN, .pinACtlIn,
        .pinACtlOut(), .pinACtlOe(), .pinBCtlIn, .pinBCtlOut(),
        .pinBCtlOe(), .inRoom());

    sppsix_host host_u (.clock, .strobedOut, .strobedOe, .strobedIn,
        .inStrobeN, .outStrobeN, .pinACtlOut, .pinACtlOe, .pinBCtlOut,
        .pinBCtlOe, .pinACtlIn, .pinBCtlIn);

    initial begin
        forever #2.5 clock = ~clock;
    end

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        nChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        sfrAddr <= a;
        sfrWdata <= v;
        sfrWrite <= 1'b1;
        @(posedge clock);
        sfrWrite <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input logic m = 1'b0);
        @(posedge clock);
        expQ.push_back(e);
        sfrAddr <= a;
        sfrRmw <= m;
        sfrRead <= 1'b1;
        @(posedge clock);
        sfrRead <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic endOfTest();
        $display("checks %0d mismatches %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Read data lands one edge after the read is taken
    always @(posedge clock) begin
        rdSeen <= sfrRead;
        if (rdSeen) begin
            check(sfrRdata, expQ.pop_front());
        end
    end

    // Sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        endOfTest();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        settle(1);
        check(portAOe, 8'h00);
        check(strobedOe, 8'h00);
        repeat (3) @(posedge clock);
        rd(ADDR_CTRL, CTRL_RESET);
        rd(ADDR_PORTA, LATCH_RESET, 1'b1);
        rd(ADDR_PORTB, LATCH_RESET, 1'b1);
        wr(ADDR_CTRL, 8'hff);
        wr(8'h10, 8'h55);
        rd(ADDR_CTRL, 8'hfc);
        rd(8'h10, 8'h00);
        for (int i = 0; i < 2; i++) begin
            d = 8'($random(seed));
            x = 8'($random(seed));
            if (i == 0) begin
                extA <= x;
            end else begin
                extB <= x;
            end
            ct = (i == 0) ? ADDR_PORTA : ADDR_PORTB;
            wr(ct, d);
            settle(1);
            check((i == 0) ? portAOut : portBOut, d);
            check((i == 0) ? portAOe : portBOe, ~d);
            rd(ct, d, 1'b1);
            if (i == 0) begin
                settle(1);
                check(narrowRdata, {4'h0, d[3:0]});
                check(8'(narrowAOut), {4'h0, d[3:0]});
            end
            rd(ct, d & x);
        end
        for (int c = 0; c < 2; c++) begin
            ct = {1'b0, c[0], 1'b0, c[0], 4'h0};
            wr(ADDR_CTRL, ct);
            settle(2);
            check(8'({pinBCtlOe, pinBCtlOut}), {7'h01, c[0]});
            check(8'({pinACtlOe, pinACtlOut}), {7'h01, c[0]});
        end
        // Fill input buffer, refuse a third word, drain
        wr(ADDR_CTRL, 8'ha0);
        d = 8'($random(seed));
        x = 8'($random(seed));
        host_u.put(d);
        rd(ADDR_CTRL, 8'ha1);
        host_u.put(x);
        settle(2);
        check(8'({inRoom, pinBCtlOut}), 8'h01);
        host_u.put(8'h5a);
        rd(ADDR_STROBED, d);
        rd(ADDR_STROBED, x);
        rd(ADDR_CTRL, 8'ha0);
        // Low-level input strobe style bypasses the buffer
        wr(ADDR_CTRL, 8'ha4);
        d = 8'($random(seed));
        host_u.put(d);
        rd(ADDR_CTRL, 8'ha5);
        rd(ADDR_STROBED, d);
        rd(ADDR_CTRL, 8'ha4);
        // Output flag cleared on falling then rising strobe edge
        for (int c = 0; c < 2; c++) begin
            ct = 8'ha0 | 8'(c << 3);
            d = 8'($random(seed));
            wr(ADDR_CTRL, ct);
            wr(ADDR_STROBED, d);
            rd(ADDR_CTRL, ct | 8'h02);
            settle(2);
            check(8'(pinACtlOut), 8'h01);
            host_u.get(x);
            check(x, d);
            rd(ADDR_CTRL, ct | 8'(c << 1));
            host_u.lift();
            rd(ADDR_CTRL, ct);
        end
        // Port disabled by enable input
        wr(ADDR_CTRL, 8'he0);
        host_u.peLvl <= 1'b1;
        host_u.put(8'h3c);
        host_u.get(x);
        check(x, 8'hff);
        host_u.lift();
        rd(ADDR_CTRL, 8'he0);
        // Select high returns control/status
        host_u.peLvl <= 1'b0;
        host_u.selLvl <= 1'b1;
        wr(ADDR_CTRL, 8'hf0);
        host_u.get(x);
        check(x, 8'hf0);
        host_u.lift();
        host_u.selLvl <= 1'b0;
        wr(ADDR_CTRL, 8'h20);
        settle(2);
        check(strobedOe, 8'hff);
        check(strobedOut, d);
        repeat (3) @(posedge clock);
        endOfTest();
    end
endmodule // tb
